/* File: pkg/power_mgmt_control_status_cfg.svh */
// offsets, field positions, reset values and fixed field values
// assumes byte-addressed configuration space, dword-aligned accesses
`ifndef POWER_MGMT_CFG_SVH
`define POWER_MGMT_CFG_SVH

// ------------------------------------------------------------
// dword addresses in configuration space
// ------------------------------------------------------------
`define CFG_PM_CAP_DWORD 8'h40
`define CFG_PM_CSR_DWORD 8'h44

// ------------------------------------------------------------
// capability header and capabilities word (upper half of 0x40)
// ------------------------------------------------------------
`define PM_CAP_ID 8'h01
`define PM_NEXT_PTR 8'h00
`define PMC_VERSION 3'h2
`define PMC_WAKE_CLOCK 1'h0
`define PMC_DSI 1'h0
`define PMC_D1_SUPPORT 1'h1
`define PMC_D2_SUPPORT 1'h1
`define PMC_WAKE_STATES 4'hf
`define PMC_AUX_CURRENT_RST 3'h0
`define PMC_D3COLD_RST 1'h0
`define PMC_AUX_LO 22
`define PMC_AUX_HI 24
`define PMC_D3COLD_BIT 31

// ------------------------------------------------------------
// control/status word (lower half of 0x44)
// ------------------------------------------------------------
`define CSR_STATE_LO 0
`define CSR_STATE_HI 1
`define CSR_ENABLE_BIT 8
`define CSR_STATUS_BIT 15
`define CSR_DATA_SELECT 4'h0
`define CSR_DATA_SCALE 2'h0
`define CSR_STATE_RST 2'h0

`endif

/* File: pkg/power_mgmt_control_status_pkg.sv */
// types shared by the power-management register block
// assumes power_mgmt_control_status_cfg.svh supplies every number
package power_mgmt_pkg;

  // power states as written to the state field
  typedef enum logic [1:0] {
    PWR_D0 = 2'b00,
    PWR_D1 = 2'b01,
    PWR_D2 = 2'b10,
    PWR_D3_HOT = 2'b11
  } power_state_t;

  // one configuration access, taken in a single cycle
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } cfg_req_t;

  // identity fields loadable from serial rom or firmware
  typedef struct packed {
    logic [2:0] aux_current;
    logic d3cold_wake;
  } ident_fields_t;

endpackage

/* File: src/pci_power_mgmt_control_status.sv */
// power-management capability and control/status registers of one
// pci function, reached by configuration cycles on the pci clock.
// assumes the i2c rom reader outside delivers decoded identity fields
// and that aux power keeps i_aux_reset low across ordinary resets.
//
// Functional notes
// - two-bit power state, reset d0, read back
// - data select and scale read zero always
// - enable bit gates the wake event output
// - wake bits sticky only with d3cold support
// - resume detect sets status regardless of enable
// - status clears only on write of one
// - non-d0 state means suspend, clock stopped
// - identity fields writable only with write enable
// - rom load completes before configuration access
// - wake output held without pci clock
// - wake capability advertised from d0 to d3hot
`include "power_mgmt_control_status_cfg.svh"
`timescale 1ns/100ps

module pci_power_mgmt_control_status
  import power_mgmt_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_aux_reset,
  input wire cfg_req_t i_cfg,
  output logic o_cfg_ready,
  output logic o_cfg_rvalid,
  output logic [31:0] o_cfg_rdata,
  input wire logic i_identity_write_enable,
  input wire logic i_rom_present,
  input wire logic i_rom_load_valid,
  input wire ident_fields_t i_rom_load_data,
  input wire logic i_rom_load_done,
  input wire logic i_resume_detected_flag,
  output power_state_t o_power_state,
  output logic o_global_suspend,
  output logic o_core_clock_enable,
  output logic o_wake_event_out,
  output logic o_wake_event_oe
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  power_state_t state_q, state_d;
  ident_fields_t ident_q, ident_d;
  logic enable_q, enable_d;
  logic status_q, status_d;
  logic loaded_q, loaded_d;
  logic sticky_q;
  logic resume_q;
  logic rvalid_q;
  logic [31:0] rdata_q, rdata_d;

  // ------------------------------------------------------------
  // access decode
  // ------------------------------------------------------------
  // accesses before the rom load is finished are ignored, so software
  // never sees identity fields half loaded
  wire logic access_ok = loaded_q;
  wire logic hit_cap = i_cfg.addr == `CFG_PM_CAP_DWORD;
  wire logic hit_csr = i_cfg.addr == `CFG_PM_CSR_DWORD;
  wire logic wr_csr = access_ok & i_cfg.wr & hit_csr;
  wire logic wr_cap = access_ok & i_cfg.wr & hit_cap;
  wire logic rd_any = access_ok & i_cfg.rd;
  wire logic wr_lane0 = wr_csr & i_cfg.be[0];
  wire logic wr_lane1 = wr_csr & i_cfg.be[1];
  wire logic ident_wr = wr_cap & i_identity_write_enable;
  wire logic aux_wr = ident_wr & i_cfg.be[2] & i_cfg.be[3];
  wire logic d3_wr = ident_wr & i_cfg.be[3];

  // resume flag edge; only the transition to one counts
  wire logic resume_rise = i_resume_detected_flag & ~resume_q;
  wire logic status_w1c = wr_lane1 & i_cfg.wdata[`CSR_STATUS_BIT];

  // ------------------------------------------------------------
  // read words
  // ------------------------------------------------------------
  // capability word: wake possible from d0 to d3hot, from d3cold as the identity field says; clock not needed
  wire logic [15:0] pmc_word = {
    ident_q.d3cold_wake,
    `PMC_WAKE_STATES,
    `PMC_D2_SUPPORT,
    `PMC_D1_SUPPORT,
    ident_q.aux_current,
    `PMC_DSI,
    1'h0,
    `PMC_WAKE_CLOCK,
    `PMC_VERSION
  };

  // data select and scale are constants; writes cannot reach them
  wire logic [15:0] csr_word = {
    status_q,
    `CSR_DATA_SCALE,
    `CSR_DATA_SELECT,
    enable_q,
    6'h00,
    state_q
  };

  wire logic [31:0] cap_dword = {pmc_word, `PM_NEXT_PTR, `PM_CAP_ID};
  // bridge extension and data bytes above read zero
  wire logic [31:0] csr_dword = {16'h0000, csr_word};

  // ------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    if (wr_lane0) begin
      state_d = power_state_t'(i_cfg.wdata[`CSR_STATE_HI:`CSR_STATE_LO]);
    end
  end

  always_comb begin
    enable_d = enable_q;
    if (wr_lane1) begin
      enable_d = i_cfg.wdata[`CSR_ENABLE_BIT];
    end
  end

  // a resume edge in the clearing cycle still leaves the flag set
  always_comb begin
    status_d = status_q;
    if (status_w1c) begin
      status_d = 1'b0;
    end
    if (resume_rise) begin
      status_d = 1'b1;
    end
  end

  // rom contents land first; firmware writes need i_identity_write_enable
  always_comb begin
    ident_d = ident_q;
    loaded_d = loaded_q;
    if (!loaded_q) begin
      if (i_rom_present && i_rom_load_valid) begin
        ident_d = i_rom_load_data;
      end
      if (!i_rom_present || i_rom_load_done) begin
        loaded_d = 1'b1;
      end
    end else begin
      if (aux_wr) begin
        ident_d.aux_current = i_cfg.wdata[`PMC_AUX_HI:`PMC_AUX_LO];
      end
      if (d3_wr) begin
        ident_d.d3cold_wake = i_cfg.wdata[`PMC_D3COLD_BIT];
      end
    end
  end

  always_comb begin
    rdata_d = 32'h0000_0000;
    if (hit_cap) begin
      rdata_d = cap_dword;
    end else if (hit_csr) begin
      rdata_d = csr_dword;
    end
  end

  // ------------------------------------------------------------
  // registers on the function reset
  // ------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      state_q <= PWR_D0;
      ident_q <= {`PMC_AUX_CURRENT_RST, `PMC_D3COLD_RST};
      loaded_q <= 1'b0;
      resume_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      state_q <= state_d;
      ident_q <= ident_d;
      loaded_q <= loaded_d;
      resume_q <= i_resume_detected_flag;
      rvalid_q <= rd_any;
      rdata_q <= rd_any ? rdata_d : rdata_q;
    end
  end

  // ------------------------------------------------------------
  // wake bits: sticky when d3cold wake is supported
  // ------------------------------------------------------------
  // d3cold support as it stood before the function reset began; the
  // identity fields clear on the first reset edge, so a reset longer
  // than one cycle must not follow them
  always_ff @(posedge i_clock) begin
    if (i_aux_reset) begin
      sticky_q <= 1'b0;
    end else if (!i_reset) begin
      sticky_q <= ident_q.d3cold_wake;
    end
  end

  // the function reset only clears them when no aux power keeps the
  // event alive; the aux reset always does
  wire logic wake_clear = i_aux_reset | (i_reset & ~sticky_q);

  always_ff @(posedge i_clock) begin
    if (wake_clear) begin
      enable_q <= 1'b0;
      status_q <= 1'b0;
    end else begin
      enable_q <= enable_d;
      status_q <= status_d;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // the wake pin is open drain, active low, driven straight from held
  // flops so it stays asserted when the pci clock is stopped
  assign o_wake_event_out = 1'b0;
  assign o_wake_event_oe = status_q & enable_q;

  // any state but d0 is global suspend; the core clock gate closes
  assign o_power_state = state_q;
  assign o_global_suspend = state_q != PWR_D0;
  assign o_core_clock_enable = state_q == PWR_D0;

  assign o_cfg_ready = loaded_q;
  assign o_cfg_rvalid = rvalid_q;
  assign o_cfg_rdata = rdata_q;

endmodule

/* File: tb/power_mgmt_control_status_checker.sv */
// assertions on the power-management register block ports
// assumes it is bound onto pci_power_mgmt_control_status
`timescale 1ns/100ps
module power_mgmt_checker
  import power_mgmt_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_aux_reset,
  input wire cfg_req_t i_cfg,
  input wire logic o_cfg_ready,
  input wire logic o_cfg_rvalid,
  input wire logic [31:0] o_cfg_rdata,
  input wire power_state_t o_power_state,
  input wire logic o_global_suspend,
  input wire logic o_core_clock_enable,
  input wire logic o_wake_event_out,
  input wire logic o_wake_event_oe
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_reset);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  sequence s_rd; o_cfg_ready && i_cfg.rd; endsequence
  sequence s_st; o_cfg_ready && i_cfg.wr && i_cfg.addr == 8'h44 && i_cfg.be[0]; endsequence
  property p_rv; s_rd |=> o_cfg_rvalid; endproperty
  a_rv: assert property (p_rv) else $error("read not answered");
  property p_gate; !o_cfg_ready |=> !o_cfg_rvalid; endproperty
  a_gate: assert property (p_gate) else $error("answer before ready");
  property p_pulse; o_cfg_rvalid |-> $past(o_cfg_ready && i_cfg.rd); endproperty
  a_pulse: assert property (p_pulse) else $error("stray read answer");
  property p_st; s_st |=> o_power_state == $past(i_cfg.wdata[1:0]); endproperty
  a_st: assert property (p_st) else $error("state not written");
  property p_sus;
    o_global_suspend == (o_power_state != PWR_D0) && o_core_clock_enable == !o_global_suspend;
  endproperty
  a_sus: assert property (p_sus) else $error("suspend mismatch");
  property p_zero;
    o_cfg_rvalid && $past(i_cfg.addr) == 8'h44 |-> o_cfg_rdata[14:9] == 6'h0;
  endproperty
  a_zero: assert property (p_zero) else $error("data fields not zero");
  // the event may only drop through a write or an aux reset
  property p_hold; o_wake_event_oe && !i_cfg.wr && !i_aux_reset |=> o_wake_event_oe; endproperty
  a_hold: assert property (p_hold) else $error("wake event dropped");
  property p_pin; o_wake_event_out == 1'b0; endproperty
  a_pin: assert property (p_pin) else $error("wake pin driven high");
endmodule

bind pci_power_mgmt_control_status power_mgmt_checker power_mgmt_checker_inst (.*);

/* File: tb/cfg_host_model.sv */
// configuration host model issuing one-cycle accesses
// assumes ready, once high, stays high until the next reset
`timescale 1ns/100ps
module cfg_host_model
  import power_mgmt_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_ready,
  input wire logic i_rvalid,
  input wire logic [31:0] i_rdata,
  output cfg_req_t o_cfg
);
  initial o_cfg = '0;
  // request held until a rising edge that sees ready high; ready is
  // looked at on the falling edge so the sample is settled
  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(negedge i_clock);
    o_cfg = '{1'b1, 1'b0, a, be, d};
    while (!i_ready) @(negedge i_clock);
    @(negedge i_clock);
    o_cfg = '0;
  endtask
  // answer is due half a cycle after the taking edge, at the next falling edge, no later
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(negedge i_clock);
    o_cfg = '{1'b0, 1'b1, a, 4'hf, 32'h0};
    while (!i_ready) @(negedge i_clock);
    @(negedge i_clock);
    o_cfg = '0;
    d = i_rvalid ? i_rdata : 'x;
  endtask
endmodule

/* File: tb/tb_top.sv */
// self-checking bench for the power-management register block
// assumes the host model and the bound checker
`timescale 1ns/100ps
module tb_top
  import power_mgmt_pkg::*;
;
  logic i_clock = 0, i_reset = 1, i_aux_reset = 1, iwe = 0, rom_p = 1, lv = 0, done = 0, flag = 0;
  ident_fields_t ld = '0;
  cfg_req_t cfg;
  logic ready, rvalid, sus, cen, wout, woe;
  logic [31:0] rdata, d;
  power_state_t ps;
  int errors = 0, samples_checked = 0;
  always #5 i_clock = ~i_clock;
  cfg_host_model cfg_host_model_inst (.i_clock(i_clock), .i_ready(ready), .i_rvalid(rvalid),
    .i_rdata(rdata), .o_cfg(cfg));
  pci_power_mgmt_control_status pci_power_mgmt_control_status_inst (.i_clock(i_clock),
    .i_reset(i_reset), .i_aux_reset(i_aux_reset), .i_cfg(cfg), .o_cfg_ready(ready),
    .o_cfg_rvalid(rvalid), .o_cfg_rdata(rdata), .i_identity_write_enable(iwe),
    .i_rom_present(rom_p), .i_rom_load_valid(lv), .i_rom_load_data(ld),
    .i_rom_load_done(done), .i_resume_detected_flag(flag), .o_power_state(ps),
    .o_global_suspend(sus), .o_core_clock_enable(cen), .o_wake_event_out(wout),
    .o_wake_event_oe(woe));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    cfg_host_model_inst.rd(a, d);
    chk(d, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge i_clock);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // a hung handshake would otherwise never end the run; the tests take
  // well under 1000 cycles, so 10000 cycles leaves ample margin
  initial begin
    #100000;
    errors++;
    finish_test;
  end
  initial begin
    cyc(10);
    i_reset = 0;
    i_aux_reset = 0;
    cyc(1);
    chk({31'h0, ready}, 32'h0);
    lv = 1;
    ld = '{3'h5, 1'b1};
    cyc(1);
    lv = 0;
    done = 1;
    cyc(1);
    chk({31'h0, ready}, 32'h1);
    done = 0;
    cyc(1);
    rchk(8'h40, 32'hff420001);
    rchk(8'h44, 32'h0);
    for (int s = 3; s >= 0; s--) begin
      cfg_host_model_inst.wr(8'h44, 4'h1, 32'(s));
      chk({30'h0, ps}, 32'(s));
      chk({31'h0, cen}, 32'(s == 0));
      rchk(8'h44, 32'(s));
      chk({31'h0, sus}, 32'(s != 0));
    end
    $display("test state done");
    cfg_host_model_inst.wr(8'h44, 4'h3, 32'h7f00);
    rchk(8'h44, 32'h0100);
    flag = 1;
    cyc(2);
    chk({31'h0, woe}, 32'h1);
    cfg_host_model_inst.wr(8'h44, 4'h2, 32'h0100);
    rchk(8'h44, 32'h8100);
    cfg_host_model_inst.wr(8'h44, 4'h2, 32'h8100);
    rchk(8'h44, 32'h0100);
    chk({31'h0, woe}, 32'h0);
    cfg_host_model_inst.wr(8'h44, 4'h2, 32'h0000);
    flag = 0;
    cyc(1);
    flag = 1;
    cyc(2);
    chk({31'h0, woe}, 32'h0);
    rchk(8'h44, 32'h8000);
    cfg_host_model_inst.wr(8'h44, 4'h2, 32'h0100);
    chk({31'h0, woe}, 32'h1);
    $display("test wake done");
    i_reset = 1;
    cyc(2);
    i_reset = 0;
    rom_p = 0;
    cyc(2);
    rchk(8'h44, 32'h8100);
    cfg_host_model_inst.wr(8'h40, 4'hc, 32'h81c00000);
    rchk(8'h40, 32'h7e020001);
    iwe = 1;
    cfg_host_model_inst.wr(8'h40, 4'hc, 32'h81c00000);
    rchk(8'h40, 32'hffc20001);
    $display("test ident done");
    finish_test;
  end
endmodule
